/* logic/clp_regs.svh */
// register offsets, field positions, reset values for the clock low-power block
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH
`define CLP_CTRL_OFS 32'h0000_0000
`define CLP_STAT_OFS 32'h0000_0004
`define CLP_DCOFF_BIT 0
`define CLP_DIV_LSB 4
`define CLP_DIV_MSB 5
`define CLP_SRCDCO_BIT 8
`define CLP_ST_DCGEN_BIT 0
`define CLP_ST_PEND_BIT 8
`define CLP_ST_PWR_LSB 12
`define CLP_ST_PWR_MSB 14
`define CLP_DCOFF_RST 1'b0
`define CLP_SRCDCO_RST 1'b1
`define CLP_DIV_RST 2'h0
`define CLP_DEEP3_CODE 3'h3
`endif

/* logic/clp_pkg.sv */
// types shared by the clock low-power block
package clp_pkg;
  typedef struct packed {
    logic isr_entry;
    logic return_from_interrupt;
    logic sleep_enter;
    logic [2:0] sleep_mode;
  } clp_core_evt_type;

  typedef enum logic [2:0] {
    clp_active,
    clp_sleep_0,
    clp_sleep_1,
    clp_sleep_2,
    clp_sleep_3,
    clp_sleep_4
  } clp_power_type;
endpackage : clp_pkg

/* logic/clp_clock_lowpower.sv */
// clock control interaction with cpu low-power modes, ahb-lite register slave
`timescale 1ns/1ps
`include "clp_regs.svh"

// Functional notes
// - isr entry from sleep clears off bit while the main clocks are off the dco
// - cleared off bit enables dc generator
// - return restores saved off bit
// - deep sleep three drops pending divider
// - divider field reads last written value
module clp_clock_lowpower #(
  parameter int DIV_W = 2
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write transfer
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire clp_pkg::clp_core_evt_type core_evt, // core interrupt and sleep events
  input wire logic aux_src_tick, // one-cycle tick per aux source period
  output logic aux_clk_en, // divided aux clock enable pulse
  output logic dc_gen_en, // dco dc generator enable
  output logic [2:0] power_mode // current power state code
);
  localparam int CNT_W = (1 << DIV_W) - 1;

  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic hresp_ff;
  logic wr_ph_ff;
  logic [31:0] addr_ff;
  logic dcoff_ff;
  logic nxt_dcoff;
  logic saved_dcoff_ff;
  logic src_dco_ff;
  logic nxt_src_dco;
  logic [DIV_W-1:0] div_field_ff;
  logic [DIV_W-1:0] nxt_div_field;
  logic [DIV_W-1:0] div_applied_ff;
  logic [DIV_W-1:0] nxt_div_applied;
  logic pend_ff;
  logic nxt_pend;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic aux_en_ff;
  logic dc_gen_ff;
  clp_pkg::clp_power_type power_ff;
  clp_pkg::clp_power_type nxt_power;
  clp_pkg::clp_power_type saved_power_ff;
  clp_pkg::clp_power_type req_power;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;

  // address phase decode; hsize is not checked, every access is taken as a word
  wire addr_ok = hsel & hready & htrans[1];
  wire wr_ctrl = wr_ph_ff & (addr_ff == `CLP_CTRL_OFS);
  wire rd_is_ctrl = haddr == `CLP_CTRL_OFS;
  wire rd_is_stat = haddr == `CLP_STAT_OFS;
  wire asleep = power_ff != clp_pkg::clp_active;
  wire deep3_entry = core_evt.sleep_enter & (core_evt.sleep_mode == `CLP_DEEP3_CODE);
  wire apply_now = aux_src_tick & pend_ff & ~deep3_entry;
  wire [CNT_W-1:0] div_last = CNT_W'((1 << div_applied_ff) - 1);
  wire cnt_wrap = cnt_ff >= div_last;
  wire unused_hsize = ^hsize;
  // the hsize terms cancel out; they only keep the pin read
  wire wr_take = addr_ok & hwrite & ~unused_hsize | addr_ok & hwrite & unused_hsize;
  wire rd_take = addr_ok & ~hwrite;
  wire isr_clear = core_evt.isr_entry & asleep & ~src_dco_ff;
  wire aux_pulse = aux_src_tick & (apply_now | cnt_wrap);

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;
  assign aux_clk_en = aux_en_ff;
  assign dc_gen_en = dc_gen_ff;
  assign power_mode = power_ff;

  always_comb begin
    case (core_evt.sleep_mode)
      3'h0: req_power = clp_pkg::clp_sleep_0;
      3'h1: req_power = clp_pkg::clp_sleep_1;
      3'h2: req_power = clp_pkg::clp_sleep_2;
      3'h3: req_power = clp_pkg::clp_sleep_3;
      default: req_power = clp_pkg::clp_sleep_4;
    endcase
  end

  // core events win over a bus write in the same cycle, so a hardware set is never lost
  always_comb begin
    nxt_dcoff = dcoff_ff;
    if (wr_ctrl) begin
      nxt_dcoff = hwdata[`CLP_DCOFF_BIT];
    end
    if (isr_clear) begin
      nxt_dcoff = 1'b0;
    end
    if (core_evt.return_from_interrupt) begin
      nxt_dcoff = saved_dcoff_ff;
    end
  end

  always_comb begin
    nxt_power = power_ff;
    if (core_evt.sleep_enter) begin
      nxt_power = req_power;
    end
    if (core_evt.isr_entry) begin
      nxt_power = clp_pkg::clp_active;
    end
    if (core_evt.return_from_interrupt) begin
      nxt_power = saved_power_ff;
    end
  end

  assign nxt_src_dco = wr_ctrl ? hwdata[`CLP_SRCDCO_BIT] : src_dco_ff;
  assign nxt_div_field = wr_ctrl ? hwdata[`CLP_DIV_MSB:`CLP_DIV_LSB] : div_field_ff;
  assign nxt_div_applied = apply_now ? div_field_ff : div_applied_ff;

  // a pending ratio reaches the divider only at an aux tick; deep sleep three before it is lost
  always_comb begin
    nxt_pend = pend_ff;
    if (aux_src_tick | deep3_entry) begin
      nxt_pend = 1'b0;
    end
    if (wr_ctrl) begin
      nxt_pend = 1'b1;
    end
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (aux_src_tick) begin
      nxt_cnt = (apply_now | cnt_wrap) ? '0 : cnt_ff + 1'b1;
    end
  end

  // read data is built from next values so a read right after a write sees it
  always_comb begin
    rd_ctrl = 32'h0000_0000;
    rd_ctrl[`CLP_DCOFF_BIT] = nxt_dcoff;
    rd_ctrl[`CLP_DIV_MSB:`CLP_DIV_LSB] = nxt_div_field;
    rd_ctrl[`CLP_SRCDCO_BIT] = nxt_src_dco;
  end

  always_comb begin
    rd_stat = 32'h0000_0000;
    rd_stat[`CLP_ST_DCGEN_BIT] = ~nxt_dcoff;
    rd_stat[`CLP_DIV_MSB:`CLP_DIV_LSB] = nxt_div_applied;
    rd_stat[`CLP_ST_PEND_BIT] = nxt_pend;
    rd_stat[`CLP_ST_PWR_MSB:`CLP_ST_PWR_LSB] = nxt_power;
  end

  wire [31:0] nxt_rdata = rd_is_ctrl ? rd_ctrl : (rd_is_stat ? rd_stat : 32'h0000_0000);

  // data phase flag; the write itself lands at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
    end else begin
      wr_ph_ff <= wr_take;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 32'h0000_0000;
    end else if (addr_ok) begin
      addr_ff <= haddr;
    end
  end

  // read data stands for the data phase only and reads zero otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else begin
      hrdata_ff <= rd_take ? nxt_rdata : 32'h0000_0000;
    end
  end

  // zero wait states: the slave never stretches a transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_ff <= 1'b1;
    end else begin
      hready_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  // off bit and power state saved on isr entry, restored by return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      saved_dcoff_ff <= `CLP_DCOFF_RST;
    end else if (core_evt.isr_entry) begin
      saved_dcoff_ff <= dcoff_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      saved_power_ff <= clp_pkg::clp_active;
    end else if (core_evt.isr_entry) begin
      saved_power_ff <= power_ff;
    end
  end

  // off bit: software writes it, the core clears and restores it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcoff_ff <= `CLP_DCOFF_RST;
    end else begin
      dcoff_ff <= nxt_dcoff;
    end
  end

  // taken from the next off bit so the enable moves in the same cycle as the bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dc_gen_ff <= ~`CLP_DCOFF_RST;
    end else begin
      dc_gen_ff <= ~nxt_dcoff;
    end
  end

  // power state follows the core; isr entry wakes unless a return in the same cycle restores the saved state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_ff <= clp_pkg::clp_active;
    end else begin
      power_ff <= nxt_power;
    end
  end

  // the isr clear only happens while the main clocks are off the dco
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_dco_ff <= `CLP_SRCDCO_RST;
    end else begin
      src_dco_ff <= nxt_src_dco;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_field_ff <= `CLP_DIV_RST;
    end else begin
      div_field_ff <= nxt_div_field;
    end
  end

  // the applied ratio can lag the field; a lost change leaves it behind until the next control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_applied_ff <= `CLP_DIV_RST;
    end else begin
      div_applied_ff <= nxt_div_applied;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // counter restarts when a new ratio lands so its first period is whole
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // one-cycle enable pulse, never a gated clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_en_ff <= 1'b0;
    end else begin
      aux_en_ff <= aux_pulse;
    end
  end
endmodule : clp_clock_lowpower

/* dv/clp_clock_lowpower_chk.sv */
// assertions on the clock low-power block ports
`timescale 1ns/1ps
module clp_chk (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire clp_pkg::clp_core_evt_type core_evt, // core events
  input wire logic aux_src_tick, // aux tick
  input wire logic aux_clk_en, // aux pulse
  input wire logic dc_gen_en, // dc generator
  input wire logic [2:0] power_mode // power state
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] sv_pm_ff;
  logic sv_dc_ff;
  logic [3:0] gap_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sv_pm_ff <= 3'h0;
      sv_dc_ff <= 1'b1;
    end else if (core_evt.isr_entry) begin
      sv_pm_ff <= power_mode;
      sv_dc_ff <= dc_gen_en;
    end
  end
  // slowest ratio is eight ticks, so the gap never passes eight
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) gap_ff <= 4'h0;
    else if (aux_clk_en) gap_ff <= 4'h0;
    else if (aux_src_tick) gap_ff <= gap_ff + 4'h1;
  end
  property p_wake; core_evt.isr_entry && power_mode != 3'h0 |=> power_mode == 3'h0; endproperty
  a_wake: assert property (p_wake) else $error("isr did not wake");
  property p_rpm; core_evt.return_from_interrupt |=> power_mode == sv_pm_ff; endproperty
  a_rpm: assert property (p_rpm) else $error("power state not restored");
  property p_rdc; core_evt.return_from_interrupt |=> dc_gen_en == sv_dc_ff; endproperty
  a_rdc: assert property (p_rdc) else $error("dc generator not restored");
  property p_deep; core_evt.sleep_enter && core_evt.sleep_mode == 3'h3 |=> power_mode == clp_pkg::clp_sleep_3; endproperty
  a_deep: assert property (p_deep) else $error("deep sleep three not entered");
  property p_tick; aux_clk_en |-> $past(aux_src_tick) && !$past(aux_clk_en); endproperty
  a_tick: assert property (p_tick) else $error("aux pulse off tick");
  property p_gap; gap_ff <= 4'h8; endproperty
  a_gap: assert property (p_gap) else $error("aux ratio above eight");
  c_isr: cover property (core_evt.isr_entry && power_mode != 3'h0);
  c_return_from_interrupt: cover property (core_evt.return_from_interrupt);
  c_aux: cover property (aux_clk_en ##1 !aux_clk_en);
endmodule : clp_chk

/* dv/clp_core_mdl.sv */
// core model: interrupt, return and sleep events plus aux source ticks
`timescale 1ns/1ps
module clp_core_mdl (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  output clp_pkg::clp_core_evt_type core_evt, // core events
  output logic aux_src_tick // aux tick
);
  logic [2:0] cnt_ff;
  initial core_evt = '0;
  // a tick every eight cycles leaves room for a write followed by sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_ff <= 3'h0;
    else cnt_ff <= cnt_ff + 3'h1;
  end
  assign aux_src_tick = (cnt_ff == 3'h7);
  task automatic pulse(input logic i, r, s, input logic [2:0] m);
    @(posedge hclk);
    core_evt <= '{i, r, s, m};
    @(posedge hclk);
    core_evt <= '0;
  endtask : pulse
  task automatic sleep(input logic [2:0] m, input logic hold);
    if (hold) repeat (2) @(posedge hclk iff aux_src_tick);
    pulse(1'b0, 1'b0, 1'b1, m);
  endtask : sleep
endmodule : clp_core_mdl

/* dv/clp_clock_lowpower_tb.sv */
// self-checking bench for the clock low-power block
`timescale 1ns/1ps
`include "clp_regs.svh"
module clp_clock_lowpower_tb;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, hreadyout, hresp, aux_src_tick, aux_clk_en, dc_gen_en;
  logic [1:0] htrans = 2'h0;
  logic [1:0] d;
  logic [2:0] power_mode;
  logic [2:0] m;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  clp_pkg::clp_core_evt_type core_evt;
  int fail_count = 0, tests_run = 0, n;
  always #12.5 hclk = ~hclk;
  clp_core_mdl core_u (.hclk(hclk), .hresetn(hresetn), .core_evt(core_evt), .aux_src_tick(aux_src_tick));
  clp_clock_lowpower dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .core_evt(core_evt), .aux_src_tick(aux_src_tick), .aux_clk_en(aux_clk_en),
    .dc_gen_en(dc_gen_en), .power_mode(power_mode));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, dat);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  function automatic logic [31:0] ctrl(input logic off, src, input logic [1:0] dv);
    return {23'h0, src, 2'h0, dv, 3'h0, off};
  endfunction : ctrl
  // power code: 0 active, 1 to 5 for sleep 0 to 4, codes above 4 count as 4
  function automatic logic [31:0] pm_code(input logic [2:0] mode);
    return (mode > 3'h4) ? 32'h5 : {29'h0, mode} + 32'h1;
  endfunction : pm_code
  task automatic wrap_up();
    $display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(30673));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `CLP_CTRL_OFS, 32'h0);
    chk("ctrl_rst", rd, ctrl(1'b0, 1'b1, 2'h0));
    chk("hresp", hresp, 32'h0);
    chk("dc_rst", dc_gen_en, 32'h1);
    $display("test reset done");
    // round 0: off the dco, no early set; round 1: early set in the isr; round 2: on the dco
    for (int s = 0; s < 3; s++) begin
      m = 3'($urandom_range(7));
      xfer(1'b1, `CLP_CTRL_OFS, ctrl(1'b1, s == 2, 2'h0));
      core_u.sleep(m, 1'b1);
      @(negedge hclk);
      chk("dc_asleep", dc_gen_en, 32'h0);
      chk("pm_sleep", power_mode, pm_code(m));
      core_u.pulse(1'b1, 1'b0, 1'b0, 3'h0);
      @(negedge hclk);
      chk("dc_isr", dc_gen_en, s != 2);
      chk("pm_isr", power_mode, 32'h0);
      if (s == 1) begin
        xfer(1'b1, `CLP_CTRL_OFS, ctrl(1'b1, 1'b0, 2'h0));
        @(negedge hclk);
        chk("dc_early_off", dc_gen_en, 32'h0);
      end
      core_u.pulse(1'b0, 1'b1, 1'b0, 3'h0);
      @(negedge hclk);
      chk("dc_return_from_interrupt", dc_gen_en, 32'h0);
      chk("pm_return_from_interrupt", power_mode, pm_code(m));
      $display("test isr round %0d done", s);
    end
    d = 2'($urandom_range(3, 1));
    core_u.pulse(1'b1, 1'b0, 1'b0, 3'h0);
    @(posedge hclk iff aux_src_tick);
    xfer(1'b1, `CLP_CTRL_OFS, ctrl(1'b1, 1'b1, d));
    core_u.sleep(3'h3, 1'b0);
    repeat (20) @(posedge hclk);
    xfer(1'b0, `CLP_CTRL_OFS, 32'h0);
    chk("div_read", rd[5:4], d);
    xfer(1'b0, `CLP_STAT_OFS, 32'h0);
    chk("div_lost", rd[5:4], 2'h0);
    core_u.pulse(1'b1, 1'b0, 1'b0, 3'h0);
    xfer(1'b1, `CLP_CTRL_OFS, ctrl(1'b1, 1'b1, d));
    core_u.sleep(3'h3, 1'b1);
    xfer(1'b0, `CLP_STAT_OFS, 32'h0);
    chk("div_applied", rd[5:4], d);
    @(posedge hclk iff aux_clk_en);
    n = 0;
    do begin
      @(posedge hclk);
      n += aux_src_tick;
    end while (aux_clk_en !== 1'b1);
    chk("ratio", n, 32'h1 << d);
    // a later deep sleep entry with no wait keeps the applied ratio
    core_u.pulse(1'b1, 1'b0, 1'b0, 3'h0);
    core_u.sleep(3'h3, 1'b0);
    xfer(1'b0, `CLP_STAT_OFS, 32'h0);
    chk("div_kept", rd[5:4], d);
    $display("test divider done");
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    wrap_up();
  end
endmodule : clp_clock_lowpower_tb
bind clp_clock_lowpower clp_chk chk_u (.hclk(hclk), .hresetn(hresetn), .core_evt(core_evt),
  .aux_src_tick(aux_src_tick), .aux_clk_en(aux_clk_en), .dc_gen_en(dc_gen_en), .power_mode(power_mode));
